/* File: branch_skip_bit_ops_unit.sv */
// Purpose: executes compare, skip, branch, io bit, shift and flag ops
// Assumes: one instruction issued per accepted cycle, pc is word address
// Notes: busy holds off issue while a multi-cycle op finishes
// Overview of operation
// RQ1: compare register with immediate, no store, update Z N V C H, one cycle
// RQ2: register bit skip passes next instruction on bit clear or set
// RQ3: io bit skip passes next instruction on bit clear or set
// RQ4: status bit branch jumps to pc plus offset plus one
// RQ5: branches on zero, carry and negative match the tested level
// RQ6: same-or-higher tests carry zero, lower tests carry one
// RQ7: signed ge tests N xor V zero, lt tests it one
// RQ8: half-carry branches test H set or clear
// RQ9: transfer-bit branches test T set or clear, flags untouched
// RQ10: overflow branches test V set or clear
// RQ11: interrupt-state branches test I set or clear
// RQ12: io bit set and clear force one io bit, two cycles
// RQ13: logical and arithmetic shifts fill correctly, update Z C N V
// RQ14: rotates pass through carry, update Z C N V
// RQ15: bit store copies bit to T, bit load copies T to bit
// RQ16: flag write sets or clears any status bit, plus dedicated variants
// RQ17: global irq on sets I in one cycle
// RQ18: untaken branch or skip one cycle, taken adds cycles
module branch_skip_bit_ops_unit (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic issue,
   input wire bsb_pkg::instr_t instr,
   input wire logic [7:0] io_rdata,
   output logic busy,
   output logic [15:0] pc,
   output logic [7:0] status_flags_register,
   output bsb_pkg::reg_wr_t reg_wr,
   output logic [5:0] io_addr,
   output logic io_we,
   output logic [7:0] io_wdata
);
   bsb_pkg::state_t state;
   bsb_pkg::state_t next_state;
   logic [1:0] wait_cnt;
   logic [1:0] next_wait_cnt;
   logic [15:0] next_pc;
   logic [7:0] next_flags;
   bsb_pkg::reg_wr_t next_reg_wr;
   logic [5:0] next_io_addr;
   logic next_io_we;
   logic [7:0] next_io_wdata;
   logic next_busy;
   logic [7:0] io_latch;
   logic [7:0] next_io_latch;
   logic [2:0] bit_latch;
   logic [2:0] next_bit_latch;
   logic set_latch;
   logic next_set_latch;
   logic [7:0] alu_result;
   logic [7:0] alu_flags;
   logic alu_writes;
   logic is_branch;
   logic is_skip;
   logic hit;
   logic [15:0] offset_ext;
   logic go;

   // datapath for compare, shifts and rotates
   bsb_alu u_alu (
      .op(instr.op),
      .a(instr.reg_val),
      .b(instr.imm),
      .flags_in(status_flags_register),
      .result(alu_result),
      .flags_out(alu_flags),
      .writes_reg(alu_writes)
   );

   // condition testing for branches and skips
   bsb_cond u_cond (
      .op(instr.op),
      .flags(status_flags_register),
      .bit_sel(instr.bit_sel),
      .reg_val(instr.reg_val),
      .io_val(io_rdata),
      .is_branch(is_branch),
      .is_skip(is_skip),
      .hit(hit)
   );

   assign go = issue && (state == bsb_pkg::ST_IDLE);
   assign offset_ext = {{9{instr.offset[6]}}, instr.offset};

   // next-state for sequencing, pc, flags and write-backs
   always_comb begin
      next_state = state;
      next_wait_cnt = wait_cnt;
      next_pc = pc;
      next_flags = status_flags_register;
      next_reg_wr = '0;
      next_io_addr = io_addr;
      next_io_we = 1'b0;
      next_io_wdata = io_wdata;
      next_io_latch = io_latch;
      next_bit_latch = bit_latch;
      next_set_latch = set_latch;
      next_busy = busy;
      case (state)
         bsb_pkg::ST_IDLE: begin
            if (go) begin
               next_pc = pc + bsb_pkg::PC_ONE;
               // io address registered, presented from the next cycle for the io write
               next_io_addr = instr.io_addr;
               if (is_branch && hit) begin
                  // relative jump costs one extra cycle RQ18
                  next_pc = pc + offset_ext + bsb_pkg::PC_ONE; // RQ4
                  next_wait_cnt = 2'd1;
                  next_state = bsb_pkg::ST_WAIT;
                  next_busy = 1'b1;
               end else if (is_skip && hit) begin
                  // skipped word count decides extra cycles RQ2 RQ3 RQ18
                  next_pc = instr.next_two_words ?
                     pc + bsb_pkg::PC_THREE : pc + bsb_pkg::PC_TWO;
                  next_wait_cnt = instr.next_two_words ? 2'd2 : 2'd1;
                  next_state = bsb_pkg::ST_WAIT;
                  next_busy = 1'b1;
               end
               case (instr.op)
                  bsb_pkg::OP_COMPARE_IMMEDIATE: begin
                     next_flags = alu_flags; // RQ1
                  end
                  bsb_pkg::OP_SHIFT_LEFT_LOGICAL,
                  bsb_pkg::OP_SHIFT_RIGHT_LOGICAL,
                  bsb_pkg::OP_SHIFT_RIGHT_ARITH,
                  bsb_pkg::OP_ROTATE_LEFT_CARRY,
                  bsb_pkg::OP_ROTATE_RIGHT_CARRY: begin
                     next_flags = alu_flags; // RQ13 RQ14
                     next_reg_wr = '{we: alu_writes, sel: instr.reg_sel,
                        data: alu_result};
                  end
                  bsb_pkg::OP_IO_BIT_SETTER,
                  bsb_pkg::OP_IO_BIT_CLEARER: begin
                     // read-modify-write over two cycles RQ12
                     next_io_latch = io_rdata;
                     next_bit_latch = instr.bit_sel;
                     next_set_latch = (instr.op == bsb_pkg::OP_IO_BIT_SETTER);
                     next_state = bsb_pkg::ST_IO_WRITE;
                     next_busy = 1'b1;
                  end
                  bsb_pkg::OP_FLAG_WRITE_ONE:
                     next_flags[instr.bit_sel] = 1'b1; // RQ16
                  bsb_pkg::OP_FLAG_WRITE_ZERO:
                     next_flags[instr.bit_sel] = 1'b0; // RQ16
                  bsb_pkg::OP_CARRY_FORCE_ONE:
                     next_flags[bsb_pkg::FLAG_C] = 1'b1; // RQ16
                  bsb_pkg::OP_CARRY_FORCE_ZERO:
                     next_flags[bsb_pkg::FLAG_C] = 1'b0; // RQ16
                  bsb_pkg::OP_NEGATIVE_FORCE_ONE:
                     next_flags[bsb_pkg::FLAG_N] = 1'b1; // RQ16
                  bsb_pkg::OP_NEGATIVE_FORCE_ZERO:
                     next_flags[bsb_pkg::FLAG_N] = 1'b0; // RQ16
                  bsb_pkg::OP_ZERO_FORCE_ONE:
                     next_flags[bsb_pkg::FLAG_Z] = 1'b1; // RQ16
                  bsb_pkg::OP_ZERO_FORCE_ZERO:
                     next_flags[bsb_pkg::FLAG_Z] = 1'b0; // RQ16
                  bsb_pkg::OP_GLOBAL_IRQ_ON:
                     next_flags[bsb_pkg::FLAG_I] = 1'b1; // RQ17
                  bsb_pkg::OP_BIT_TO_XFER_FLAG:
                     next_flags[bsb_pkg::FLAG_T] =
                        instr.reg_val[instr.bit_sel]; // RQ15
                  bsb_pkg::OP_XFER_FLAG_TO_BIT: begin
                     next_reg_wr.we = 1'b1; // RQ15
                     next_reg_wr.sel = instr.reg_sel;
                     next_reg_wr.data = instr.reg_val;
                     next_reg_wr.data[instr.bit_sel] =
                        status_flags_register[bsb_pkg::FLAG_T];
                  end
                  default: begin
                     next_reg_wr = '0;
                  end
               endcase
            end
         end
         bsb_pkg::ST_WAIT: begin
            // pipeline refill after a taken branch or skip
            next_wait_cnt = wait_cnt - 2'd1;
            if (wait_cnt == 2'd1) begin
               next_state = bsb_pkg::ST_IDLE;
               next_busy = 1'b0;
            end
         end
         bsb_pkg::ST_IO_WRITE: begin
            next_io_we = 1'b1; // RQ12
            next_io_wdata = io_latch;
            next_io_wdata[bit_latch] = set_latch;
            next_state = bsb_pkg::ST_IDLE;
            next_busy = 1'b0;
         end
         default: begin
            next_state = bsb_pkg::ST_IDLE;
            next_busy = 1'b0;
         end
      endcase
   end

   // registers only; every output comes straight from here
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         state <= bsb_pkg::ST_IDLE;
         wait_cnt <= 2'd0;
         pc <= bsb_pkg::PC_RESET;
         status_flags_register <= bsb_pkg::FLAGS_RESET;
         reg_wr <= '0;
         io_addr <= 6'h00;
         io_we <= 1'b0;
         io_wdata <= 8'h00;
         io_latch <= 8'h00;
         bit_latch <= 3'h0;
         set_latch <= 1'b0;
         busy <= 1'b0;
      end else begin
         state <= next_state;
         wait_cnt <= next_wait_cnt;
         pc <= next_pc;
         status_flags_register <= next_flags;
         reg_wr <= next_reg_wr;
         io_addr <= next_io_addr;
         io_we <= next_io_we;
         io_wdata <= next_io_wdata;
         io_latch <= next_io_latch;
         bit_latch <= next_bit_latch;
         set_latch <= next_set_latch;
         busy <= next_busy;
      end
   end
endmodule

/* File: bsb_pkg.sv */
// Purpose: shared constants and types for the branch/skip/bit unit
// Assumes: 8-bit data, 16-bit word program counter, 6-bit io address
// Notes: status bit order is carry..irq enable, bit 0 to bit 7
package bsb_pkg;
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [15:0] PC_ONE = 16'h0001;
   localparam logic [15:0] PC_TWO = 16'h0002;
   localparam logic [15:0] PC_THREE = 16'h0003;

   typedef enum logic [5:0] {
      OP_NONE = 6'h00,
      OP_COMPARE_IMMEDIATE = 6'h01,
      OP_SKIP_REG_BIT_CLEAR = 6'h02,
      OP_SKIP_REG_BIT_ONE = 6'h03,
      OP_SKIP_IO_BIT_CLEAR = 6'h04,
      OP_SKIP_IO_BIT_ONE = 6'h05,
      OP_BRANCH_FLAG_ONE = 6'h06,
      OP_BRANCH_FLAG_ZERO = 6'h07,
      OP_BRANCH_EQUAL = 6'h08,
      OP_BRANCH_NOT_EQUAL = 6'h09,
      OP_BRANCH_CARRY_ONE = 6'h0A,
      OP_BRANCH_CARRY_ZERO = 6'h0B,
      OP_BRANCH_SAME_HIGHER = 6'h0C,
      OP_BRANCH_LOWER = 6'h0D,
      OP_BRANCH_MINUS = 6'h0E,
      OP_BRANCH_PLUS = 6'h0F,
      OP_BRANCH_SIGNED_GE = 6'h10,
      OP_BRANCH_SIGNED_LT = 6'h11,
      OP_BRANCH_HALFCARRY_ONE = 6'h12,
      OP_BRANCH_HALFCARRY_ZERO = 6'h13,
      OP_BRANCH_XFER_ONE = 6'h14,
      OP_BRANCH_XFER_ZERO = 6'h15,
      OP_BRANCH_OVERFLOW_ONE = 6'h16,
      OP_BRANCH_OVERFLOW_ZERO = 6'h17,
      OP_BRANCH_IRQ_ON = 6'h18,
      OP_BRANCH_IRQ_OFF = 6'h19,
      OP_IO_BIT_SETTER = 6'h1A,
      OP_IO_BIT_CLEARER = 6'h1B,
      OP_SHIFT_LEFT_LOGICAL = 6'h1C,
      OP_SHIFT_RIGHT_LOGICAL = 6'h1D,
      OP_ROTATE_LEFT_CARRY = 6'h1E,
      OP_ROTATE_RIGHT_CARRY = 6'h1F,
      OP_SHIFT_RIGHT_ARITH = 6'h20,
      OP_FLAG_WRITE_ONE = 6'h21,
      OP_FLAG_WRITE_ZERO = 6'h22,
      OP_BIT_TO_XFER_FLAG = 6'h23,
      OP_XFER_FLAG_TO_BIT = 6'h24,
      OP_CARRY_FORCE_ONE = 6'h25,
      OP_CARRY_FORCE_ZERO = 6'h26,
      OP_NEGATIVE_FORCE_ONE = 6'h27,
      OP_NEGATIVE_FORCE_ZERO = 6'h28,
      OP_ZERO_FORCE_ONE = 6'h29,
      OP_ZERO_FORCE_ZERO = 6'h2A,
      OP_GLOBAL_IRQ_ON = 6'h2B
   } op_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_WAIT = 4'b0010,
      ST_IO_WRITE = 4'b0100,
      ST_SPARE = 4'b1000
   } state_t;

   // one decoded instruction as issued by the fetch stage
   typedef struct packed {
      op_t op;
      logic [4:0] reg_sel;
      logic [7:0] reg_val;
      logic [7:0] imm;
      logic [2:0] bit_sel;
      logic [5:0] io_addr;
      logic [6:0] offset;
      logic next_two_words;
   } instr_t;

   // register-file write-back
   typedef struct packed {
      logic we;
      logic [4:0] sel;
      logic [7:0] data;
   } reg_wr_t;
endpackage

/* File: bsb_alu.sv */
// Purpose: combinational compare, shift and rotate datapath
// Assumes: operands are stable for the issue cycle
// Notes: sign flag s is derived as n xor v for every update
module bsb_alu (
   input wire bsb_pkg::op_t op,
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic [7:0] flags_in,
   output logic [7:0] result,
   output logic [7:0] flags_out,
   output logic writes_reg
);
   logic [8:0] diff;
   logic c;
   logic n;
   logic v;
   // compute the result and the flags it touches
   always_comb begin
      diff = {1'b0, a} - {1'b0, b};
      result = a;
      flags_out = flags_in;
      writes_reg = 1'b0;
      c = flags_in[bsb_pkg::FLAG_C];
      case (op)
         bsb_pkg::OP_COMPARE_IMMEDIATE: begin
            result = diff[7:0]; // not written back RQ1
            c = diff[8];
            flags_out[bsb_pkg::FLAG_H] = (~a[3] & b[3]) | (b[3] & diff[3])
               | (diff[3] & ~a[3]);
         end
         bsb_pkg::OP_SHIFT_LEFT_LOGICAL: begin
            result = {a[6:0], 1'b0}; // RQ13
            c = a[7];
            writes_reg = 1'b1;
         end
         bsb_pkg::OP_SHIFT_RIGHT_LOGICAL: begin
            result = {1'b0, a[7:1]}; // RQ13
            c = a[0];
            writes_reg = 1'b1;
         end
         bsb_pkg::OP_SHIFT_RIGHT_ARITH: begin
            result = {a[7], a[7:1]}; // RQ13
            c = a[0];
            writes_reg = 1'b1;
         end
         bsb_pkg::OP_ROTATE_LEFT_CARRY: begin
            result = {a[6:0], flags_in[bsb_pkg::FLAG_C]}; // RQ14
            c = a[7];
            writes_reg = 1'b1;
         end
         bsb_pkg::OP_ROTATE_RIGHT_CARRY: begin
            result = {flags_in[bsb_pkg::FLAG_C], a[7:1]}; // RQ14
            c = a[0];
            writes_reg = 1'b1;
         end
         default: begin
            result = a;
         end
      endcase
      n = result[7];
      // shifts take v as n xor c; compare uses signed overflow
      if (op == bsb_pkg::OP_COMPARE_IMMEDIATE) begin
         v = (a[7] & ~b[7] & ~diff[7]) | (~a[7] & b[7] & diff[7]);
      end else begin
         v = n ^ c;
      end
      if (op == bsb_pkg::OP_COMPARE_IMMEDIATE || writes_reg) begin
         flags_out[bsb_pkg::FLAG_C] = c; // RQ1 RQ13 RQ14
         flags_out[bsb_pkg::FLAG_Z] = (result == 8'h00);
         flags_out[bsb_pkg::FLAG_N] = n;
         flags_out[bsb_pkg::FLAG_V] = v;
         flags_out[bsb_pkg::FLAG_S] = n ^ v;
      end
   end
endmodule

/* File: bsb_cond.sv */
// Purpose: branch and skip condition evaluation
// Assumes: flags are the current status register contents
// Notes: pure combinational, no state
module bsb_cond (
   input wire bsb_pkg::op_t op,
   input wire logic [7:0] flags,
   input wire logic [2:0] bit_sel,
   input wire logic [7:0] reg_val,
   input wire logic [7:0] io_val,
   output logic is_branch,
   output logic is_skip,
   output logic hit
);
   // flag tested against a wanted level
   function automatic logic match(input logic f, input logic want);
      match = (f == want);
   endfunction
   always_comb begin
      is_branch = 1'b1;
      is_skip = 1'b0;
      hit = 1'b0;
      case (op)
         bsb_pkg::OP_BRANCH_FLAG_ONE:
            hit = match(flags[bit_sel], 1'b1); // RQ4
         bsb_pkg::OP_BRANCH_FLAG_ZERO:
            hit = match(flags[bit_sel], 1'b0); // RQ4
         bsb_pkg::OP_BRANCH_EQUAL:
            hit = match(flags[bsb_pkg::FLAG_Z], 1'b1); // RQ5
         bsb_pkg::OP_BRANCH_NOT_EQUAL:
            hit = match(flags[bsb_pkg::FLAG_Z], 1'b0); // RQ5
         bsb_pkg::OP_BRANCH_CARRY_ONE, bsb_pkg::OP_BRANCH_LOWER:
            hit = match(flags[bsb_pkg::FLAG_C], 1'b1); // RQ5 RQ6
         bsb_pkg::OP_BRANCH_CARRY_ZERO, bsb_pkg::OP_BRANCH_SAME_HIGHER:
            hit = match(flags[bsb_pkg::FLAG_C], 1'b0); // RQ5 RQ6
         bsb_pkg::OP_BRANCH_MINUS:
            hit = match(flags[bsb_pkg::FLAG_N], 1'b1); // RQ5
         bsb_pkg::OP_BRANCH_PLUS:
            hit = match(flags[bsb_pkg::FLAG_N], 1'b0); // RQ5
         bsb_pkg::OP_BRANCH_SIGNED_GE:
            hit = match(flags[bsb_pkg::FLAG_N] ^ flags[bsb_pkg::FLAG_V],
               1'b0); // RQ7
         bsb_pkg::OP_BRANCH_SIGNED_LT:
            hit = match(flags[bsb_pkg::FLAG_N] ^ flags[bsb_pkg::FLAG_V],
               1'b1); // RQ7
         bsb_pkg::OP_BRANCH_HALFCARRY_ONE:
            hit = match(flags[bsb_pkg::FLAG_H], 1'b1); // RQ8
         bsb_pkg::OP_BRANCH_HALFCARRY_ZERO:
            hit = match(flags[bsb_pkg::FLAG_H], 1'b0); // RQ8
         bsb_pkg::OP_BRANCH_XFER_ONE:
            hit = match(flags[bsb_pkg::FLAG_T], 1'b1); // RQ9
         bsb_pkg::OP_BRANCH_XFER_ZERO:
            hit = match(flags[bsb_pkg::FLAG_T], 1'b0); // RQ9
         bsb_pkg::OP_BRANCH_OVERFLOW_ONE:
            hit = match(flags[bsb_pkg::FLAG_V], 1'b1); // RQ10
         bsb_pkg::OP_BRANCH_OVERFLOW_ZERO:
            hit = match(flags[bsb_pkg::FLAG_V], 1'b0); // RQ10
         bsb_pkg::OP_BRANCH_IRQ_ON:
            hit = match(flags[bsb_pkg::FLAG_I], 1'b1); // RQ11
         bsb_pkg::OP_BRANCH_IRQ_OFF:
            hit = match(flags[bsb_pkg::FLAG_I], 1'b0); // RQ11
         bsb_pkg::OP_SKIP_REG_BIT_CLEAR: begin
            is_branch = 1'b0;
            is_skip = 1'b1;
            hit = match(reg_val[bit_sel], 1'b0); // RQ2
         end
         bsb_pkg::OP_SKIP_REG_BIT_ONE: begin
            is_branch = 1'b0;
            is_skip = 1'b1;
            hit = match(reg_val[bit_sel], 1'b1); // RQ2
         end
         bsb_pkg::OP_SKIP_IO_BIT_CLEAR: begin
            is_branch = 1'b0;
            is_skip = 1'b1;
            hit = match(io_val[bit_sel], 1'b0); // RQ3
         end
         bsb_pkg::OP_SKIP_IO_BIT_ONE: begin
            is_branch = 1'b0;
            is_skip = 1'b1;
            hit = match(io_val[bit_sel], 1'b1); // RQ3
         end
         default: begin
            is_branch = 1'b0;
         end
      endcase
   end
endmodule

/* File: bsb_monitor.sv */
// Purpose: port-level checker for the branch/skip/bit unit
// Assumes: issue is taken only while busy is low
// Notes: bound to the top module at the foot of this file
module bsb_monitor (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic issue,
   input wire bsb_pkg::instr_t instr,
   input wire logic [7:0] io_rdata,
   input wire logic busy,
   input wire logic [15:0] pc,
   input wire logic [7:0] status_flags_register,
   input wire bsb_pkg::reg_wr_t reg_wr,
   input wire logic [5:0] io_addr,
   input wire logic io_we,
   input wire logic [7:0] io_wdata
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   logic go;
   logic [7:0] f;
   logic [15:0] tgt;
   // accepted issue, flag view and relative target shared below
   assign go = issue && !busy;
   assign f = status_flags_register;
   assign tgt = pc + {{9{instr.offset[6]}}, instr.offset} + 16'h0001;
   property p_flag;
      go && instr.op == bsb_pkg::OP_FLAG_WRITE_ONE |=> !busy &&
         f[$past(instr.bit_sel)] && pc == $past(pc) + 16'h0001;
   endproperty
   a_flag: assert property (p_flag)
      else $error("flag write one missed");
   property p_irq;
      go && instr.op == bsb_pkg::OP_GLOBAL_IRQ_ON |=> f[7] && !busy;
   endproperty
   a_irq: assert property (p_irq)
      else $error("irq enable not set");
   property p_beq;
      go && instr.op == bsb_pkg::OP_BRANCH_EQUAL && f[1]
         |=> busy && pc == $past(tgt) ##1 !busy;
   endproperty
   a_beq: assert property (p_beq)
      else $error("equal branch wrong");
   property p_bne;
      go && instr.op == bsb_pkg::OP_BRANCH_NOT_EQUAL && f[1]
         |=> !busy && pc == $past(pc) + 16'h0001;
   endproperty
   a_bne: assert property (p_bne)
      else $error("untaken branch wrong");
   property p_blt;
      go && instr.op == bsb_pkg::OP_BRANCH_SIGNED_LT && (f[2] ^ f[3])
         |=> busy && pc == $past(tgt);
   endproperty
   a_blt: assert property (p_blt)
      else $error("signed less branch wrong");
   property p_skip3;
      go && instr.op == bsb_pkg::OP_SKIP_REG_BIT_ONE &&
         instr.reg_val[instr.bit_sel] && instr.next_two_words
         |=> busy [*2] ##1 (!busy && pc == $past(pc, 3) + 16'h0003);
   endproperty
   a_skip3: assert property (p_skip3)
      else $error("two word skip wrong");
   property p_sbi;
      go && instr.op == bsb_pkg::OP_IO_BIT_SETTER
         |=> busy && io_addr == $past(instr.io_addr) ##1 io_we && !busy &&
         io_wdata == ($past(io_rdata, 2)
         | (8'h01 << $past(instr.bit_sel, 2)));
   endproperty
   a_sbi: assert property (p_sbi)
      else $error("io bit set wrong");
   property p_we;
      io_we |=> !io_we;
   endproperty
   a_we: assert property (p_we)
      else $error("io write longer than one cycle");
   property p_cpi;
      go && instr.op == bsb_pkg::OP_COMPARE_IMMEDIATE
         |=> !reg_wr.we && !busy && f[7:6] == $past(f[7:6]);
   endproperty
   a_cpi: assert property (p_cpi)
      else $error("compare wrote or stalled");
   property p_bst;
      go && instr.op == bsb_pkg::OP_BIT_TO_XFER_FLAG
         |=> f[6] == $past(instr.reg_val[instr.bit_sel]);
   endproperty
   a_bst: assert property (p_bst)
      else $error("bit store wrong");
   c_clr: cover property (go && instr.op == bsb_pkg::OP_IO_BIT_CLEARER);
   c_skip: cover property (go && instr.op == bsb_pkg::OP_SKIP_IO_BIT_ONE);
   c_busy: cover property (issue && busy);
endmodule

bind branch_skip_bit_ops_unit bsb_monitor mon_u (
   .clk_sys(clk_sys), .resetn(resetn), .issue(issue), .instr(instr),
   .io_rdata(io_rdata), .busy(busy), .pc(pc),
   .status_flags_register(status_flags_register), .reg_wr(reg_wr),
   .io_addr(io_addr), .io_we(io_we), .io_wdata(io_wdata)
);

/* File: branch_skip_bit_ops_unit_tb.sv */
// Purpose: self-checking bench for the branch/skip/bit unit
// Assumes: pc and flags are tracked by the bench model
// Notes: every op waits out busy before the next is issued
module branch_skip_bit_ops_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic issue = 1'b0;
   bsb_pkg::instr_t instr = '0;
   bsb_pkg::instr_t i;
   logic [7:0] io_rdata = 8'h00;
   logic busy, io_we;
   logic [15:0] pc, xpc;
   logic [7:0] flags, io_wdata, xf, r, a, b;
   logic [5:0] io_addr;
   bsb_pkg::reg_wr_t reg_wr, saw_wr;
   logic saw_we, c;
   logic [7:0] saw_wd;
   int mismatches = 0;
   int tests_run = 0;
   int ncyc;
   localparam int FB[7] = '{0, 0, 2, 2, 1, 1, 7};
   branch_skip_bit_ops_unit dut_u (.clk_sys(clk_sys), .resetn(resetn),
      .issue(issue), .instr(instr), .io_rdata(io_rdata), .busy(busy),
      .pc(pc), .status_flags_register(flags), .reg_wr(reg_wr),
      .io_addr(io_addr), .io_we(io_we), .io_wdata(io_wdata));
   always #2.5 clk_sys = ~clk_sys;
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // issue one op, hold issue for hold extra edges, then count busy cycles
   task automatic run(input bsb_pkg::instr_t n, input logic [7:0] v,
                      input int hold);
      @(posedge clk_sys);
      instr <= n;
      io_rdata <= v;
      issue <= 1'b1;
      repeat (hold + 1) @(posedge clk_sys);
      issue <= 1'b0;
      #1;
      saw_wr = reg_wr;
      saw_we = io_we;
      saw_wd = io_wdata;
      ncyc = 1;
      while (busy === 1'b1 && ncyc < 8) begin
         @(posedge clk_sys);
         #1;
         ncyc++;
         saw_we = io_we;
         saw_wd = io_wdata;
      end
   endtask
   task automatic step(input logic [7:0] v, input logic [15:0] np,
                       input int cyc);
      run(i, v, 0);
      xpc = np;
      check(pc, xpc);
      check(flags, xf);
      check(16'(ncyc), 16'(cyc));
   endtask
   task automatic set_flags(input logic [7:0] p);
      for (int k = 0; k < 8; k++) begin
         i = '0;
         i.op = p[k] ? bsb_pkg::OP_FLAG_WRITE_ONE
            : bsb_pkg::OP_FLAG_WRITE_ZERO;
         i.bit_sel = 3'(k);
         xf[k] = p[k];
         step(8'h00, xpc + 16'h0001, 1);
      end
   endtask
   // tested level per op pair; the odd op of each pair inverts it, except pairs 3 and 5 where the even op inverts it
   function automatic logic hit_of(input logic [5:0] o, input logic [7:0] f,
                                   input logic [2:0] s);
      logic [9:0] t;
      logic [5:0] k;
      t = {f[7], f[3], f[6], f[5], f[2] ^ f[3], f[2], f[0], f[0], f[1], f[s]};
      k = o - 6'h06;
      return t[k >> 1] ^ k[0] ^ (k[5:1] == 5'h03 || k[5:1] == 5'h05);
   endfunction
   initial begin
      #100us;
      mismatches++;
      report_and_stop();
   end
   initial begin
      repeat (16) @(posedge clk_sys);
      resetn <= 1'b1;
      #1;
      check(pc, 16'h0000);
      check({busy, io_we, reg_wr.we, flags}, 11'h000);
      xpc = 16'h0000;
      xf = 8'h00;
      for (int k = 0; k < 7; k++) begin
         i = '0;
         i.op = bsb_pkg::op_t'(6'(6'h25 + k));
         xf[FB[k]] = ~k[0];
         step(8'h00, xpc + 16'h0001, 1);
      end
      foreach (FB[p]) begin
         set_flags(8'(40'h68_28_04_FF_00 >> (8 * (p % 5))));
         for (int k = 6; k < 26; k++) begin
            i = '0;
            i.op = bsb_pkg::op_t'(6'(k));
            i.bit_sel = 3'(k);
            i.offset = k[0] ? 7'h40 : 7'h3F;
            if (hit_of(6'(k), xf, i.bit_sel))
               step(0, xpc + {{9{i.offset[6]}}, i.offset} + 16'h1, 2);
            else step(8'h00, xpc + 16'h0001, 1);
         end
      end
      // hold issue across the busy cycle: the extra edge must be ignored
      i.op = bsb_pkg::OP_BRANCH_XFER_ONE;
      run(i, 8'h00, 1);
      xpc = xpc + {{9{i.offset[6]}}, i.offset} + 16'h0001;
      check(pc, xpc);
      for (int k = 2; k < 6; k++) begin
         for (int s = 0; s < 4; s++) begin
            i = '0;
            i.op = bsb_pkg::op_t'(6'(k));
            i.reg_val = 8'hA5;
            i.bit_sel = 3'(s);
            i.next_two_words = s[1];
            if (8'hA5 >> s & 1 ^ ~k[0] & 1)
               step(8'hA5, xpc + 16'(2 + s / 2), 2 + s / 2);
            else step(8'hA5, xpc + 16'h0001, 1);
         end
      end
      for (int k = 0; k < 2; k++) begin
         i = '0;
         i.op = bsb_pkg::op_t'(6'(6'h1A + k));
         i.io_addr = 6'h2A;
         i.bit_sel = 3'(k);
         step(8'h5A, xpc + 16'h0001, 2);
         check({saw_we, saw_wd, io_addr},
            {1'b1, k ? 8'h58 : 8'h5B, 6'h2A});
      end
      for (int k = 0; k < 10; k++) begin
         i = '0;
         i.op = bsb_pkg::op_t'(6'(6'h1C + k / 2));
         i.reg_sel = 5'(k + 3);
         a = k[0] ? 8'h00 : 8'h81;
         i.reg_val = a;
         case (k / 2)
            0: {c, r} = {a, 1'b0};
            1: {r, c} = {1'b0, a};
            2: {c, r} = {a, xf[0]};
            3: {r, c} = {xf[0], a};
            default: {r, c} = {a[7], a};
         endcase
         xf[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
         xf[4] = c;
         step(8'h00, xpc + 16'h0001, 1);
         check({saw_wr.we, saw_wr.sel, saw_wr.data},
            {1'b1, i.reg_sel, r});
      end
      for (int k = 0; k < 4; k++) begin
         a = 8'(32'h00_05_80_10 >> (8 * k));
         b = 8'(32'h01_05_01_01 >> (8 * k));
         i = '0;
         i.op = bsb_pkg::OP_COMPARE_IMMEDIATE;
         i.reg_val = a;
         i.imm = b;
         r = a - b;
         xf[5] = ~a[3] & b[3] | b[3] & r[3] | r[3] & ~a[3];
         xf[0] = ~a[7] & b[7] | b[7] & r[7] | r[7] & ~a[7];
         xf[3] = a[7] & ~b[7] & ~r[7] | ~a[7] & b[7] & r[7];
         xf[2:1] = {r[7], r == 8'h00};
         xf[4] = xf[2] ^ xf[3];
         step(8'h00, xpc + 16'h0001, 1);
         check(saw_wr.we, 1'b0);
      end
      for (int k = 0; k < 2; k++) begin
         i = '0;
         i.op = bsb_pkg::OP_BIT_TO_XFER_FLAG;
         i.reg_val = 8'h20 >> k;
         i.bit_sel = 3'h5;
         xf[6] = ~k[0];
         step(8'h00, xpc + 16'h0001, 1);
         i.op = bsb_pkg::OP_XFER_FLAG_TO_BIT;
         i.reg_val = 8'h5A;
         i.bit_sel = 3'h0;
         step(8'h00, xpc + 16'h0001, 1);
         check(saw_wr.data, {7'h2D, ~k[0]});
      end
      // second reset in mid-run, then a plain op must restart from pc 0
      @(posedge clk_sys);
      resetn <= 1'b0;
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      #1;
      check(pc, bsb_pkg::PC_RESET);
      check(flags, bsb_pkg::FLAGS_RESET);
      xf = bsb_pkg::FLAGS_RESET;
      i = '0;
      step(8'h00, bsb_pkg::PC_ONE, 1);
      report_and_stop();
   end
endmodule
